// file: include/bpd_pkg.sv
// Purpose : Shared constants and carrier types of the breakpoint debug unit
// Assumes : 32-bit linear addresses; one core clock
// Notes   : Register indexes are the numbers used by the register transfer port

package bpd_pkg;

    // ==========================================================
    // Register indexes
    localparam logic [2:0] IDX_BP0    = 3'h0;
    localparam logic [2:0] IDX_BP1    = 3'h1;
    localparam logic [2:0] IDX_BP2    = 3'h2;
    localparam logic [2:0] IDX_BP3    = 3'h3;
    localparam logic [2:0] IDX_STATUS = 3'h6;
    localparam logic [2:0] IDX_CTRL   = 3'h7;

    // ==========================================================
    // Debug control layout
    localparam int         NUM_BP       = 4;
    localparam int         CTRL_DIS_BIT = 13;
    localparam int         CTRL_RW_LSB  = 16;
    localparam int         CTRL_LEN_LSB = 18;
    localparam int         CTRL_BP_STEP = 4;
    localparam logic [31:0] CTRL_WMASK  = 32'hFFFF_20FF;
    localparam logic [31:0] CTRL_LOCALS = 32'h0000_0055;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

    // ==========================================================
    // Debug status layout
    localparam logic [31:0] STAT_WMASK  = 32'h0000_000F;
    localparam logic [31:0] STAT_ONES   = 32'h0000_0FF0;
    localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;

    // ==========================================================
    // Field encodings
    localparam logic [1:0] RW_EXEC   = 2'h0;
    localparam logic [1:0] RW_WRITE  = 2'h1;
    localparam logic [1:0] RW_RDWR   = 2'h3;
    localparam logic [1:0] LEN_ONE   = 2'h0;
    localparam logic [1:0] LEN_TWO   = 2'h1;
    localparam logic [1:0] LEN_FOUR  = 2'h3;
    localparam logic [1:0] CPL_TOP   = 2'h0;

    typedef enum logic [1:0] {
        BPD_FETCH,
        BPD_READ,
        BPD_WRITE
    } bpd_kind_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [1:0]  size;
        bpd_kind_t   kind;
    } bpd_access_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [2:0]  idx;
        logic [31:0] wdata;
        logic [1:0]  cpl;
    } bpd_reg_req_t;

endpackage : bpd_pkg

// file: verilog/bpd_match.sv
// Purpose : One breakpoint comparator: access kind and byte overlap
// Assumes : Accesses do not cross an aligned doubleword
// Notes   : Unused codes of either field never match

`timescale 1ns/1ps

module bpd_match
(
    // Breakpoint setup
    input  wire logic [31:0]         bp_addr,
    input  wire logic [1:0]          bp_rw,
    input  wire logic [1:0]          bp_len,
    // Observed access
    input  wire bpd_pkg::bpd_access_t acc,
    // Result
    output logic                     hit
);

    logic [3:0] bp_mask;
    logic [3:0] acc_mask;
    logic       kind_ok;
    logic       len_ok;

    // ==========================================================
    // Byte masks within the doubleword
    function automatic logic [3:0] byte_mask(input logic [1:0] lo, input logic [1:0] len);
        logic [3:0] m;
        m = 4'h0;
        unique case (len)
            bpd_pkg::LEN_ONE:  m = 4'h1 << lo;
            bpd_pkg::LEN_TWO:  m = lo[1] ? 4'hC : 4'h3;
            bpd_pkg::LEN_FOUR: m = 4'hF;
            default:           m = 4'h0;
        endcase
        return m;
    endfunction : byte_mask

    always_comb
    begin
        bp_mask  = byte_mask(bp_addr[1:0], bp_len);
        acc_mask = byte_mask(acc.addr[1:0], acc.size);
        len_ok   = (bp_len != 2'h2);
        kind_ok  = 1'b0;
        unique case (bp_rw)
            bpd_pkg::RW_EXEC:  kind_ok = (acc.kind == bpd_pkg::BPD_FETCH);
            bpd_pkg::RW_WRITE: kind_ok = (acc.kind == bpd_pkg::BPD_WRITE);
            bpd_pkg::RW_RDWR:  kind_ok = (acc.kind == bpd_pkg::BPD_READ)
                                      || (acc.kind == bpd_pkg::BPD_WRITE);
            default:           kind_ok = 1'b0;
        endcase
        // Any shared byte counts as a hit
        hit = acc.valid && kind_ok && len_ok
           && (bp_addr[31:2] == acc.addr[31:2])
           && ((bp_mask & acc_mask) != 4'h0);
    end

endmodule : bpd_match

// file: verilog/bpd_top.sv
// Purpose : Hardware breakpoint unit: address, control and status registers
// Assumes : Core holds a fetched instruction until debug_exc_r is seen
// Notes   : Registers are reached only by the register transfer port

`timescale 1ns/1ps

module bpd_top
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // Core access watch
    input  wire bpd_pkg::bpd_access_t  acc,
    input  wire logic                  task_switch,
    // Register transfer port
    input  wire bpd_pkg::bpd_reg_req_t req,
    output logic [31:0]                rd_data_r,
    output logic                       rd_valid_r,
    output logic                       access_fault_r,
    // Exception request
    output logic                       debug_exc_r,
    output logic [3:0]                 exc_hits_r
);

    logic [31:0] bp_addr_r   [bpd_pkg::NUM_BP];
    logic [31:0] bp_addr_nxt [bpd_pkg::NUM_BP];
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [31:0] status_r;
    logic [31:0] status_nxt;
    logic [31:0] rd_data_nxt;
    logic        rd_valid_nxt;
    logic        access_fault_nxt;
    logic        debug_exc_nxt;
    logic [3:0]  exc_hits_nxt;
    logic [3:0]  match;
    logic [3:0]  en_hit;
    logic        req_ok;
    logic        exc;

    // ==========================================================
    // Comparators
    genvar gi;
    generate
        for (gi = 0; gi < bpd_pkg::NUM_BP; gi++)
        begin : g_bp
            bpd_match u_match
            (
                .bp_addr (bp_addr_r[gi]),
                .bp_rw   (ctrl_r[bpd_pkg::CTRL_RW_LSB  + gi*bpd_pkg::CTRL_BP_STEP +: 2]),
                .bp_len  (ctrl_r[bpd_pkg::CTRL_LEN_LSB + gi*bpd_pkg::CTRL_BP_STEP +: 2]),
                .acc     (acc),
                .hit     (match[gi])
            );
            // Local or global enable arms the breakpoint
            assign en_hit[gi] = match[gi] && (ctrl_r[2*gi] || ctrl_r[2*gi+1]);
        end
    endgenerate

    // ==========================================================
    // Next state
    always_comb
    begin
        for (int i = 0; i < bpd_pkg::NUM_BP; i++)
        begin
            bp_addr_nxt[i] = bp_addr_r[i];
        end
        ctrl_nxt         = ctrl_r;
        status_nxt       = status_r;
        rd_data_nxt      = 32'h0000_0000;
        exc              = |en_hit;
        // Access disable blocks every transfer, the control register included
        req_ok           = req.valid && (req.cpl == bpd_pkg::CPL_TOP)
                        && !ctrl_r[bpd_pkg::CTRL_DIS_BIT];
        rd_valid_nxt     = req_ok && !req.write;
        access_fault_nxt = req.valid && !req_ok;
        debug_exc_nxt    = exc;
        exc_hits_nxt     = exc ? match : 4'h0;

        if (req_ok && req.write)
        begin
            unique case (req.idx)
                bpd_pkg::IDX_BP0,
                bpd_pkg::IDX_BP1,
                bpd_pkg::IDX_BP2,
                bpd_pkg::IDX_BP3: bp_addr_nxt[req.idx[1:0]] = req.wdata;
                // Fixed bits are forced, so a careless write cannot disturb them
                bpd_pkg::IDX_STATUS: status_nxt = (req.wdata & bpd_pkg::STAT_WMASK)
                                                | bpd_pkg::STAT_ONES;
                bpd_pkg::IDX_CTRL:   ctrl_nxt   = req.wdata & bpd_pkg::CTRL_WMASK;
                default: ;
            endcase
        end

        if (req_ok && !req.write)
        begin
            unique case (req.idx)
                bpd_pkg::IDX_BP0,
                bpd_pkg::IDX_BP1,
                bpd_pkg::IDX_BP2,
                bpd_pkg::IDX_BP3:    rd_data_nxt = bp_addr_r[req.idx[1:0]];
                bpd_pkg::IDX_STATUS: rd_data_nxt = status_r;
                bpd_pkg::IDX_CTRL:   rd_data_nxt = ctrl_r;
                default:             rd_data_nxt = 32'h0000_0000;
            endcase
        end

        if (task_switch)
        begin
            ctrl_nxt = ctrl_nxt & ~bpd_pkg::CTRL_LOCALS;
        end

        if (exc)
        begin
            ctrl_nxt[bpd_pkg::CTRL_DIS_BIT] = 1'b0;
            // Hit bits record every matching breakpoint, armed or not; set wins
            status_nxt[3:0] = status_nxt[3:0] | match;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < bpd_pkg::NUM_BP; i++)
            begin
                bp_addr_r[i] <= bpd_pkg::ADDR_RESET;
            end
            ctrl_r         <= bpd_pkg::CTRL_RESET;
            status_r       <= bpd_pkg::STAT_ONES;
            rd_data_r      <= 32'h0000_0000;
            rd_valid_r     <= 1'b0;
            access_fault_r <= 1'b0;
            debug_exc_r    <= 1'b0;
            exc_hits_r     <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < bpd_pkg::NUM_BP; i++)
            begin
                bp_addr_r[i] <= bp_addr_nxt[i];
            end
            ctrl_r         <= ctrl_nxt;
            status_r       <= status_nxt;
            rd_data_r      <= rd_data_nxt;
            rd_valid_r     <= rd_valid_nxt;
            access_fault_r <= access_fault_nxt;
            debug_exc_r    <= debug_exc_nxt;
            exc_hits_r     <= exc_hits_nxt;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_priv_req;
        req.valid && (req.cpl == bpd_pkg::CPL_TOP) && !ctrl_r[bpd_pkg::CTRL_DIS_BIT];
    endsequence

    sequence s_write_bp1;
        s_priv_req ##0 (req.write && (req.idx == bpd_pkg::IDX_BP1));
    endsequence

    chk_exc_on_hit: assert property (acc.valid && (en_hit != 4'h0) |=> debug_exc_r)
        else $error("armed match gave no debug exception");
    chk_no_exc_idle: assert property ((en_hit == 4'h0) |=> !debug_exc_r)
        else $error("debug exception without armed match");
    chk_priv_fault: assert property (req.valid && (req.cpl != bpd_pkg::CPL_TOP)
        |=> access_fault_r && !rd_valid_r)
        else $error("unprivileged transfer not refused");
    chk_bp_write: assert property (s_write_bp1 |=> bp_addr_r[1] == $past(req.wdata))
        else $error("address register write lost");
    chk_read_back: assert property (s_write_bp1 ##1 (s_priv_req ##0 (!req.write
        && req.idx == bpd_pkg::IDX_BP1 && !task_switch))
        |=> rd_valid_r && (rd_data_r == $past(req.wdata, 2)))
        else $error("address register read mismatch");
    chk_dis_cleared: assert property (debug_exc_r |-> !ctrl_r[bpd_pkg::CTRL_DIS_BIT])
        else $error("access disable survived debug exception");
    chk_local_clear: assert property (task_switch |=> (ctrl_r & bpd_pkg::CTRL_LOCALS) == 32'h0)
        else $error("local enable survived task switch");
    chk_status_hold: assert property (!exc && !(req_ok && req.write && req.idx == bpd_pkg::IDX_STATUS)
        |=> $stable(status_r))
        else $error("status changed without cause");
    chk_hit_capture: assert property (debug_exc_r |-> ((status_r[3:0] & exc_hits_r) == exc_hits_r))
        else $error("hit bits not captured");
    chk_fixed_ones: assert property (status_r[11:4] == 8'hFF)
        else $error("fixed status bits disturbed");

endmodule : bpd_top

// file: test/bpd_core_model.sv
// Purpose : Core-side model: register transfers, watched accesses, task switches
// Assumes : One request per task call (two for wr_rd), raised just after a rising edge
// Notes   : Idle fields carry noise so stale values are never trusted

`timescale 1ns/1ps

module bpd_core_model
(
    // Clock
    input  wire logic             sys_clk,
    // Core side
    output bpd_pkg::bpd_access_t  acc,
    output bpd_pkg::bpd_reg_req_t req,
    output logic                  task_switch
);
    initial
    begin
        acc         = '0;
        req         = '0;
        task_switch = 1'b0;
    end

    // ==========================================================
    // Register transfer at a chosen privilege level
    task automatic reg_op(input logic wr, input logic [2:0] idx,
                          input logic [31:0] d, input logic [1:0] cpl);
        @(posedge sys_clk);
        req <= '{1'b1, wr, idx, d, cpl};
        @(posedge sys_clk);
        req <= '{1'b0, 1'b0, 3'h0, 32'($urandom), 2'h3};
    endtask : reg_op

    // ==========================================================
    // Write then read back on the very next cycle, no idle gap
    task automatic wr_rd(input logic [2:0] idx, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b1, idx, d, bpd_pkg::CPL_TOP};
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, idx, 32'($urandom), bpd_pkg::CPL_TOP};
        @(posedge sys_clk);
        req <= '{1'b0, 1'b0, 3'h0, 32'($urandom), 2'h3};
    endtask : wr_rd

    // ==========================================================
    // One watched access, then noise on the released fields
    task automatic access(input logic [31:0] a, input logic [1:0] sz,
                          input bpd_pkg::bpd_kind_t k);
        @(posedge sys_clk);
        acc <= '{1'b1, a, sz, k};
        @(posedge sys_clk);
        acc <= '{1'b0, 32'($urandom), 2'($urandom), bpd_pkg::BPD_READ};
    endtask : access

    // ==========================================================
    // Task switch pulse
    task automatic tswitch();
        @(posedge sys_clk);
        task_switch <= 1'b1;
        @(posedge sys_clk);
        task_switch <= 1'b0;
    endtask : tswitch
endmodule : bpd_core_model

// file: test/testbench.sv
// Purpose : Self-checking bench of the breakpoint unit with an ordered scoreboard
// Assumes : Expected events enter the queue in the order they appear
// Notes   : Queue entry is kind (0 read, 1 refusal, 2 exception) and data

`timescale 1ns/1ps

module testbench;
    logic                  sys_clk;
    logic                  rst_n;
    bpd_pkg::bpd_access_t  acc;
    bpd_pkg::bpd_reg_req_t req;
    logic                  task_switch;
    logic [31:0]           rd_data_r;
    logic                  rd_valid_r;
    logic                  access_fault_r;
    logic                  debug_exc_r;
    logic [3:0]            exc_hits_r;
    logic [33:0]           exp_q[$];
    logic [33:0]           mon_e;
    logic [31:0]           v;
    logic [31:0]           base;
    logic                  hit;
    int                    n;
    int                    fails;
    int                    n_checks;
    int                    seed_v;

    bpd_core_model model (.sys_clk(sys_clk), .acc(acc), .req(req), .task_switch(task_switch));

    bpd_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .acc(acc), .task_switch(task_switch),
                 .req(req), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
                 .access_fault_r(access_fault_r), .debug_exc_r(debug_exc_r),
                 .exc_hits_r(exc_hits_r));

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd(input logic [2:0] idx, input logic [31:0] e);
        exp_q.push_back({2'd0, e});
        model.reg_op(1'b0, idx, 32'h0000_0000, bpd_pkg::CPL_TOP);
    endtask : rd

    task automatic wr(input logic [2:0] idx, input logic [31:0] d);
        model.reg_op(1'b1, idx, d, bpd_pkg::CPL_TOP);
    endtask : wr

    task automatic wrrd(input logic [2:0] idx, input logic [31:0] d);
        exp_q.push_back({2'd0, d});
        model.wr_rd(idx, d);
    endtask : wrrd

    task automatic wrap_up();
        if (exp_q.size() != 0)
            fails++;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Monitor: every answer pulse takes the oldest note
    always @(negedge sys_clk)
    begin
        if (rd_valid_r === 1'b1 || access_fault_r === 1'b1 || debug_exc_r === 1'b1)
        begin
            mon_e = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
            if (rd_valid_r === 1'b1)
                check({2'd0, rd_data_r}, mon_e);
            else if (access_fault_r === 1'b1)
                check({2'd1, 32'h0000_0000}, mon_e);
            else
                check({2'd2, 28'h000_0000, exc_hits_r}, mon_e);
        end
    end

    // Watchdog sized well above the few thousand cycles the tests need
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        wrap_up();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        rst_n    = 1'b0;
        fails    = 0;
        n_checks = 0;
        seed_v   = $urandom(12341);
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(3'(i), (i == 6) ? bpd_pkg::STAT_ONES : 32'h0000_0000);
        $display("test reset values done");

        for (int i = 0; i < 4; i++)
        begin
            v = $urandom;
            wrrd(3'(i), v);
        end
        wr(3'h4, 32'($urandom));
        rd(3'h4, 32'h0000_0000);
        // Reserved control bits kept at zero by software
        v = $urandom & bpd_pkg::CTRL_WMASK & ~(32'h0000_0001 << bpd_pkg::CTRL_DIS_BIT);
        wr(bpd_pkg::IDX_CTRL, v);
        rd(bpd_pkg::IDX_CTRL, v);
        $display("test register access done");

        base = $urandom & 32'hFFFF_FFFC;
        wr(bpd_pkg::IDX_BP0, base ^ 32'h0000_0100);
        wr(bpd_pkg::IDX_BP1, base);
        for (int rw = 0; rw < 4; rw++)
            for (int ln = 0; ln < 4; ln++)
                for (int k = 0; k < 3; k++)
                    for (int s = 0; s < 4; s++)
                        for (int o = 0; o < 4 && s != 2; o += (s == 3) ? 4 : s + 1)
                        begin
                            v = 32'h0000_0004 | (32'(rw) << (bpd_pkg::CTRL_RW_LSB + 4))
                                | (32'(ln) << (bpd_pkg::CTRL_LEN_LSB + 4));
                            wr(bpd_pkg::IDX_CTRL, v);
                            wr(bpd_pkg::IDX_STATUS, bpd_pkg::STAT_ONES);
                            n   = (ln == 3) ? 4 : ((ln == 2) ? 0 : ln + 1);
                            hit = (o < n) && ((rw == 0 && k == 0) || (rw == 1 && k == 2)
                                  || (rw == 3 && k != 0));
                            if (hit)
                                exp_q.push_back({2'd2, 32'h0000_0002});
                            model.access(base + 32'(o), 2'(s), bpd_pkg::bpd_kind_t'(k));
                            rd(bpd_pkg::IDX_STATUS, bpd_pkg::STAT_ONES | (hit ? 32'h2 : 32'h0));
                        end
        $display("test match table done");

        exp_q.push_back({2'd1, 32'h0000_0000});
        model.reg_op(1'b0, bpd_pkg::IDX_BP0, 32'h0000_0000, 2'h3);
        wr(bpd_pkg::IDX_CTRL, 32'h0000_2004);
        exp_q.push_back({2'd1, 32'h0000_0000});
        model.reg_op(1'b0, bpd_pkg::IDX_CTRL, 32'h0000_0000, bpd_pkg::CPL_TOP);
        exp_q.push_back({2'd2, 32'h0000_0002});
        model.access(base, bpd_pkg::LEN_ONE, bpd_pkg::BPD_FETCH);
        rd(bpd_pkg::IDX_CTRL, 32'h0000_0004);
        $display("test access refusal done");

        wr(bpd_pkg::IDX_CTRL, 32'h0000_0006);
        model.tswitch();
        rd(bpd_pkg::IDX_CTRL, 32'h0000_0002);
        wr(bpd_pkg::IDX_STATUS, bpd_pkg::STAT_ONES);
        model.access(base, bpd_pkg::LEN_ONE, bpd_pkg::BPD_FETCH);
        rd(bpd_pkg::IDX_STATUS, bpd_pkg::STAT_ONES);
        // Unarmed breakpoint 2 on the same byte must still be recorded
        wr(bpd_pkg::IDX_BP2, base ^ 32'h0000_0100);
        exp_q.push_back({2'd2, 32'h0000_0005});
        model.access(base ^ 32'h0000_0100, bpd_pkg::LEN_ONE, bpd_pkg::BPD_FETCH);
        rd(bpd_pkg::IDX_STATUS, bpd_pkg::STAT_ONES | 32'h0000_0005);
        $display("test task switch done");

        repeat (4) @(posedge sys_clk);
        wrap_up();
    end
endmodule : testbench
